// file: hw/tmr2_pkg.sv
// What this block does
// - one 16-bit counter, low and high bytes
// - timer at osc/6 (osc in baud), counter on pin falls
// - mode chosen from run, uart, select and clock-out enable bits
// - control at C8H, resets 00H, flag bits
// - overflow flag only outside baud/clock-out
// - edge flag set on enabled trigger fall, except when stopped, in clock-out or down count
// - both flags share one interrupt request
// - rx clock from our or other overflows
// - tx clock from our or other overflows
// - trigger enable gates all trigger events
// - run bit starts and stops counting
// - select picks capture or reload action
// - clock-out enable drives pin enable in all modes
// - down count enable allows up/down reload
// - capture without trigger is plain counter
// - trigger fall copies count into capture
// - capture never reloads, counting continues
// - each capture overwrites capture pair
// - edge takes three machine cycles
// - up overflow reloads from capture pair
// - down underflow at capture, reloads FFFFH
package tmr2_pkg;
   // ---------------------------------------------
   // register addresses
   // ---------------------------------------------
   localparam logic [7:0] ADR_CTL   = 8'hC8; // control
   localparam logic [7:0] ADR_MOD   = 8'hC9; // mode
   localparam logic [7:0] ADR_CAPL  = 8'hCA; // capture low
   localparam logic [7:0] ADR_CAPH  = 8'hCB; // capture high
   localparam logic [7:0] ADR_CNTL  = 8'hCC; // count low
   localparam logic [7:0] ADR_CNTH  = 8'hCD; // count high
   localparam logic [7:0] ADR_IEN   = 8'hCE; // irq enable
   // ---------------------------------------------
   // field positions and values
   // ---------------------------------------------
   localparam int         B_OVF     = 7;
   localparam int         B_EXF     = 6;
   localparam int         B_RCLK    = 5;
   localparam int         B_TX_CLOCK_SELECT    = 4;
   localparam int         B_EXEN    = 3;
   localparam int         B_RUN     = 2;
   localparam int         B_SRC     = 1;
   localparam int         B_CPRL    = 0;
   localparam int         B_OE      = 1;
   localparam int         B_DOWN_COUNT_ENABLE    = 0;
   localparam logic [7:0] CTL_RST   = 8'h00;
   localparam logic [1:0] MOD_RST   = 2'h0;
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   localparam logic [2:0] MC_LAST   = 3'h5; // osc/6
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      M_OFF  = 3'b000,
      M_AUTO = 3'b001,
      M_CAPT = 3'b010,
      M_CLKO = 3'b011,
      M_BAUD = 3'b100
   } tmr2_mode_t;
   typedef struct packed {
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
      logic       wr;    // write strobe
      logic       rd;    // read strobe
   } tmr2_bus_t;
endpackage

// file: hw/tmr2_core.sv
`timescale 1ns/1ns
`default_nettype none
module tmr2_core
   import tmr2_pkg::*;
(
   input  wire logic      core_clk,
   input  wire logic      reset,
   input  wire tmr2_bus_t bus,
   output var  logic [7:0] rd_data_q,
   input  wire logic      count_input_pin,
   input  wire logic      trigger_pin,
   input  wire logic      t1_ovf_tick,
   output var  logic      rx_baud_tick_q,
   output var  logic      tx_baud_tick_q,
   output var  logic      clk_out_q,
   output var  logic      clk_out_oe_n_q,
   output var  logic      irq_q
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   logic [7:0]  ctl_q;     // control register
   logic [1:0]  mod_q;     // mode bits 1:0
   logic        ien_q;     // interrupt enable
   logic [15:0] cnt_q;     // count pair
   logic [15:0] cap_q;     // capture pair
   logic [2:0]  mc_q;      // machine cycle div
   logic        mc_tick;   // one per machine cycle
   logic        cin_prv_q; // count pin sample
   logic        trg_prv_q; // trigger sample
   logic        trg_det_q; // high then low seen
   tmr2_mode_t  mode;      // decoded mode
   logic        inc_en;    // count step
   logic        down;      // counting down
   logic        ovf_evt;   // up rollover
   logic        unf_evt;   // down underflow
   logic        trg_act;   // accepted trigger
   logic        uart_sel;  // serial port clocking
   logic        wr_ctl;    // control write
   logic        ovf_set;   // overflow flag set
   logic        exf_set;   // edge flag set
   logic        exf_tgl;   // edge flag toggle

   // mode decode, used by logic and checks
   function automatic tmr2_mode_t dec_mode(
      input logic [7:0] c,
      input logic [1:0] m
   );
      if (!c[B_RUN])
         return M_OFF;
      else if (c[B_RCLK] | c[B_TX_CLOCK_SELECT])
         return M_BAUD;
      else if (c[B_CPRL])
         return M_CAPT;
      else if (m[B_OE])
         return M_CLKO;
      else
         return M_AUTO;
   endfunction

   // ---------------------------------------------
   // machine cycle divider
   // ---------------------------------------------
   // one pulse every six oscillator clocks
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         mc_q <= 3'h0;
      else if (mc_q == MC_LAST)
         mc_q <= 3'h0;
      else
         mc_q <= mc_q + 3'h1;
   end
   assign mc_tick = (mc_q == MC_LAST);

   // ---------------------------------------------
   // pin sampling
   // ---------------------------------------------
   // both pins sampled once per machine cycle
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         cin_prv_q <= 1'b0;
         trg_prv_q <= 1'b0;
         trg_det_q <= 1'b0;
      end
      else if (mc_tick)
      begin
         cin_prv_q <= count_input_pin;
         trg_prv_q <= trigger_pin;
         // high sample then low sample
         trg_det_q <= trg_prv_q & ~trigger_pin;
      end
   end

   // ---------------------------------------------
   // count control
   // ---------------------------------------------
   // mode, direction and events
   always_comb
   begin
      mode     = dec_mode(ctl_q, mod_q);
      uart_sel = ctl_q[B_RCLK] | ctl_q[B_TX_CLOCK_SELECT];
      // stopped unless run bit set
      if (mode == M_OFF)
         inc_en = 1'b0;
      else if (ctl_q[B_SRC])
         // pin fall seen at a tick: max osc/12
         inc_en = mc_tick & cin_prv_q & ~count_input_pin;
      else if (mode == M_BAUD)
         inc_en = 1'b1;
      else
         inc_en = mc_tick;
      // up/down only in auto-reload
      down    = (mode == M_AUTO) & mod_q[B_DOWN_COUNT_ENABLE] & ~trigger_pin;
      ovf_evt = inc_en & ~down & (cnt_q == CNT_MAX);
      unf_evt = inc_en & down & (cnt_q == cap_q);
      // trigger fall used only when enabled; trigger level sets down direction regardless
      trg_act = mc_tick & trg_det_q & ctl_q[B_EXEN]
              & ((mode == M_CAPT) | (mode == M_BAUD)
              | ((mode == M_AUTO) & ~mod_q[B_DOWN_COUNT_ENABLE]));
      // no flag in baud or clock-out
      ovf_set = (ovf_evt | unf_evt)
              & ((mode == M_AUTO) | (mode == M_CAPT));
      exf_set = trg_act;
      exf_tgl = (ovf_evt | unf_evt) & (mode == M_AUTO)
              & mod_q[B_DOWN_COUNT_ENABLE];
      wr_ctl  = bus.wr & (bus.addr == ADR_CTL);
   end

   // ---------------------------------------------
   // counter
   // ---------------------------------------------
   // software write, reload or step
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         cnt_q <= 16'h0000;
      else if (bus.wr && bus.addr == ADR_CNTL)
         cnt_q[7:0] <= bus.wdata;
      else if (bus.wr && bus.addr == ADR_CNTH)
         cnt_q[15:8] <= bus.wdata;
      else if (unf_evt)
         cnt_q <= CNT_MAX;
      else if (ovf_evt && mode != M_CAPT)
         // serial clocking forces reload
         cnt_q <= cap_q;
      else if (trg_act && mode == M_AUTO)
         cnt_q <= cap_q;
      else if (inc_en && down)
         cnt_q <= cnt_q - 16'h0001;
      else if (inc_en)
         // capture mode wraps, never reloads
         cnt_q <= cnt_q + 16'h0001;
   end

   // ---------------------------------------------
   // capture pair
   // ---------------------------------------------
   // overwritten on every capture
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         cap_q <= 16'h0000;
      else if (trg_act && mode == M_CAPT)
         cap_q <= cnt_q;
      else if (bus.wr && bus.addr == ADR_CAPL)
         cap_q[7:0] <= bus.wdata;
      else if (bus.wr && bus.addr == ADR_CAPH)
         cap_q[15:8] <= bus.wdata;
   end

   // ---------------------------------------------
   // control, mode and enable registers
   // ---------------------------------------------
   // flags: hardware set wins over clear
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         ctl_q <= CTL_RST;
      else
      begin
         if (wr_ctl)
            ctl_q[5:0] <= bus.wdata[5:0];
         // set by hardware or a control write, cleared by software
         ctl_q[B_OVF] <= ovf_set
                       | (wr_ctl ? bus.wdata[B_OVF] : ctl_q[B_OVF]);
         if (exf_set)
            ctl_q[B_EXF] <= 1'b1;
         else if (exf_tgl)
            ctl_q[B_EXF] <= ~(wr_ctl ? bus.wdata[B_EXF]
                                     : ctl_q[B_EXF]);
         else if (wr_ctl)
            ctl_q[B_EXF] <= bus.wdata[B_EXF];
      end
   end

   // mode register keeps its low two bits
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         mod_q <= MOD_RST;
      else if (bus.wr && bus.addr == ADR_MOD)
         mod_q <= bus.wdata[1:0];
   end

   // interrupt enable bit
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         ien_q <= 1'b0;
      else if (bus.wr && bus.addr == ADR_IEN)
         ien_q <= bus.wdata[0];
   end

   // ---------------------------------------------
   // read port
   // ---------------------------------------------
   // data one cycle after the strobe, else zero
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         rd_data_q <= 8'h00;
      else if (!bus.rd)
         rd_data_q <= 8'h00;
      else
         case (bus.addr)
            ADR_CTL:  rd_data_q <= ctl_q;
            ADR_MOD:  rd_data_q <= {6'h00, mod_q};
            ADR_CAPL: rd_data_q <= cap_q[7:0];
            ADR_CAPH: rd_data_q <= cap_q[15:8];
            ADR_CNTL: rd_data_q <= cnt_q[7:0];
            ADR_CNTH: rd_data_q <= cnt_q[15:8];
            ADR_IEN:  rd_data_q <= {7'h00, ien_q};
            default:  rd_data_q <= 8'h00;
         endcase
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // uart clocks, clock-out pin and interrupt
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         rx_baud_tick_q <= 1'b0;
         tx_baud_tick_q <= 1'b0;
         clk_out_q      <= 1'b0;
         clk_out_oe_n_q <= 1'b1;
         irq_q          <= 1'b0;
      end
      else
      begin
         // our overflow or the other timer's
         rx_baud_tick_q <= ctl_q[B_RCLK] ? (ovf_evt & uart_sel)
                                         : t1_ovf_tick;
         tx_baud_tick_q <= ctl_q[B_TX_CLOCK_SELECT] ? (ovf_evt & uart_sel)
                                         : t1_ovf_tick;
         // toggles on each clock-out rollover
         if (mode == M_CLKO && ovf_evt)
            clk_out_q <= ~clk_out_q;
         clk_out_oe_n_q <= ~mod_q[B_OE];
         // shared request for both causes
         irq_q <= ien_q & (ctl_q[B_OVF] | ctl_q[B_EXF]);
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence s_cap_evt;
      trg_act && mode == M_CAPT;
   endsequence
   sequence s_quiet_wr;
      !bus.wr;
   endsequence

   property p_ovf_mode;
      $rose(ctl_q[B_OVF]) && !$past(wr_ctl)
         |-> $past(mode == M_AUTO || mode == M_CAPT);
   endproperty
   a_ovf_mode: assert property (p_ovf_mode)
      else $error("overflow flag set in wrong mode");

   property p_capture;
      s_cap_evt |=> cap_q == $past(cnt_q) && ctl_q[B_EXF];
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture pair or edge flag wrong");

   property p_edge_steps;
      mc_tick && trigger_pin ##6 mc_tick && !trigger_pin
         ##6 (mc_tick && ctl_q[B_EXEN] && mode == M_CAPT)
         |=> ctl_q[B_EXF];
   endproperty
   a_edge_steps: assert property (p_edge_steps)
      else $error("edge flag not set in third cycle");

   property p_reload_up;
      (ovf_evt && mode == M_AUTO) and s_quiet_wr
         |=> cnt_q == $past(cap_q) && ctl_q[B_OVF];
   endproperty
   a_reload_up: assert property (p_reload_up)
      else $error("up reload missing");

   property p_underflow;
      unf_evt and s_quiet_wr |=> cnt_q == CNT_MAX;
   endproperty
   a_underflow: assert property (p_underflow)
      else $error("underflow did not reload all ones");

   property p_stopped;
      !ctl_q[B_RUN] and s_quiet_wr |=> $stable(cnt_q);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("counter moved while stopped");

   property p_irq;
      ien_q && (ctl_q[B_OVF] || ctl_q[B_EXF]) |=> irq_q;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");

   property p_tx_tick;
      ctl_q[B_TX_CLOCK_SELECT] && ovf_evt |=> tx_baud_tick_q;
   endproperty
   a_tx_tick: assert property (p_tx_tick)
      else $error("transmit clock tick missing");

   property p_ctl_read;
      bus.rd && bus.addr == ADR_CTL |=> rd_data_q == $past(ctl_q);
   endproperty
   a_ctl_read: assert property (p_ctl_read)
      else $error("control read wrong");

endmodule // tmr2_core
`default_nettype wire

// file: verification/tmr2_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// far side: count pin, trigger pin, other timer
// ---------------------------------------------
module tmr2_pins_model
(
   input  wire logic core_clk,
   output var  logic count_input_pin,
   output var  logic trigger_pin,
   output var  logic t1_ovf_tick
);
   // pins idle high, no tick from the other timer
   initial
   begin
      count_input_pin = 1'b1;
      trigger_pin     = 1'b1;
      t1_ovf_tick     = 1'b0;
   end
   // wait a number of rising edges
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one count pin fall, two machine cycles low and high
   task automatic pin_fall();
      @(posedge core_clk);
      count_input_pin <= 1'b0;
      hold(12);
      count_input_pin <= 1'b1;
      hold(12);
   endtask
   // trigger fall held past the three-sample window
   task automatic trig_fall();
      @(posedge core_clk);
      trigger_pin <= 1'b0;
      hold(24);
      trigger_pin <= 1'b1;
      hold(12);
   endtask
   // trigger as a direction level
   task automatic set_trig(input logic lvl);
      @(posedge core_clk);
      trigger_pin <= lvl;
      hold(12);
   endtask
   // one overflow pulse of the other timer
   task automatic t1_pulse();
      @(posedge core_clk);
      t1_ovf_tick <= 1'b1;
      @(posedge core_clk);
      t1_ovf_tick <= 1'b0;
      hold(8);
   endtask
endmodule // tmr2_pins_model
`default_nettype wire

// file: verification/timer2_capture_reload_counter_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module timer2_capture_reload_counter_test
   import tmr2_pkg::*;
();
   logic       core_clk;    // 100 MHz
   logic       reset;       // active high
   tmr2_bus_t  bus;         // register port
   logic [7:0] rd_data_q;   // read data
   logic       cnt_pin, trg_pin, t1_tick;
   logic       rx_tick, tx_tick, clk_out, oe_n, irq_q;
   int         n_fail, comparisons, tx_n, rx_n, co_n;
   logic [7:0] v;           // scratch read value
   // ---------------------------------------------
   // clock, design and far side
   // ---------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   tmr2_core dut (.core_clk(core_clk), .reset(reset), .bus(bus),
      .rd_data_q(rd_data_q), .count_input_pin(cnt_pin),
      .trigger_pin(trg_pin), .t1_ovf_tick(t1_tick),
      .rx_baud_tick_q(rx_tick), .tx_baud_tick_q(tx_tick),
      .clk_out_q(clk_out), .clk_out_oe_n_q(oe_n), .irq_q(irq_q));
   tmr2_pins_model pins (.core_clk(core_clk), .count_input_pin(cnt_pin),
      .trigger_pin(trg_pin), .t1_ovf_tick(t1_tick));
   // tick and toggle counters
   always @(posedge core_clk)
   begin
      if (tx_tick === 1'b1) tx_n++;
      if (rx_tick === 1'b1) rx_n++;
   end
   always @(clk_out) co_n++;
   // ---------------------------------------------
   // bus tasks
   // ---------------------------------------------
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge core_clk);
      bus.wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge core_clk);
      bus.rd   <= 1'b0;
      #1 d = rd_data_q;
   endtask
   task automatic cr(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask
   task automatic wcnt(input logic [7:0] h, input logic [7:0] l);
      wr(ADR_CNTH, h);
      wr(ADR_CNTL, l);
   endtask
   task automatic wcap(input logic [7:0] h, input logic [7:0] l);
      wr(ADR_CAPH, h);
      wr(ADR_CAPL, l);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // run limit
   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      $display("BAD %0t run too long", $time);
      print_verdict();
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial
   begin
      n_fail = 0;
      comparisons = 0;
      bus = '0;
      reset = 1'b1;
      idle(10);
      reset <= 1'b0;
      // reset values, reserved bits, stop and timer rate
      cr(ADR_CTL, 8'h00);
      cr(ADR_MOD, 8'h00);
      `CHK(oe_n, 1'b1)
      cr(8'h00, 8'h00);
      wr(ADR_MOD, 8'hFF);
      cr(ADR_MOD, 8'h03);
      wr(ADR_MOD, 8'h00);
      wr(ADR_CNTL, 8'h55);
      idle(30);
      cr(ADR_CNTL, 8'h55);
      wr(ADR_CTL, 8'h04);
      idle(58);
      rd(ADR_CNTL, v);
      `CHK(v >= 8'h5E && v <= 8'h60, 1'b1)
      wr(ADR_CTL, 8'h00);
      $display("test 1 done");
      // capture on trigger, overwrite, no reload
      wr(ADR_IEN, 8'h01);
      wcnt(8'h12, 8'h34);
      wr(ADR_CTL, 8'h0F);
      pins.trig_fall();
      cr(ADR_CAPL, 8'h34);
      cr(ADR_CAPH, 8'h12);
      cr(ADR_CTL, 8'h4F);
      `CHK(irq_q, 1'b1)
      repeat (3) pins.pin_fall();
      pins.trig_fall();
      cr(ADR_CAPL, 8'h37);
      cr(ADR_CNTL, 8'h37);
      wr(ADR_CTL, 8'h0F);
      idle(3);
      `CHK(irq_q, 1'b0)
      $display("test 2 done");
      // plain counter overflow, trigger ignored
      wr(ADR_CTL, 8'h07);
      wcnt(8'hFF, 8'hFE);
      repeat (2) pins.pin_fall();
      cr(ADR_CNTL, 8'h00);
      cr(ADR_CNTH, 8'h00);
      pins.trig_fall();
      cr(ADR_CTL, 8'h87);
      cr(ADR_CAPL, 8'h37);
      `CHK(irq_q, 1'b1)
      $display("test 3 done");
      // up auto-reload on overflow and on trigger
      wr(ADR_CTL, 8'h00);
      wcap(8'hAB, 8'h00);
      wcnt(8'hFF, 8'hFF);
      wr(ADR_CTL, 8'h0E);
      pins.pin_fall();
      cr(ADR_CNTH, 8'hAB);
      cr(ADR_CNTL, 8'h00);
      cr(ADR_CTL, 8'h8E);
      pins.pin_fall();
      pins.trig_fall();
      cr(ADR_CNTL, 8'h00);
      cr(ADR_CTL, 8'hCE);
      $display("test 4 done");
      // down count, underflow at the capture pair
      wr(ADR_CTL, 8'h00);
      wr(ADR_MOD, 8'h01);
      wcap(8'h00, 8'h10);
      wcnt(8'h00, 8'h11);
      pins.set_trig(1'b0);
      wr(ADR_CTL, 8'h06);
      repeat (2) pins.pin_fall();
      cr(ADR_CNTL, 8'hFF);
      cr(ADR_CNTH, 8'hFF);
      cr(ADR_CTL, 8'hC6);
      wr(ADR_CTL, 8'h00);
      pins.set_trig(1'b1);
      wr(ADR_MOD, 8'h00);
      $display("test 5 done");
      // baud ticks, no overflow flag
      wcap(8'hFF, 8'hF0);
      wcnt(8'hFF, 8'hF0);
      wr(ADR_CTL, 8'h1C);
      idle(20);
      tx_n = 0;
      rx_n = 0;
      repeat (3) pins.t1_pulse();
      idle(130);
      `CHK(tx_n, 10)
      `CHK(rx_n, 3)
      pins.trig_fall();
      cr(ADR_CTL, 8'h5C);
      // receive clock from our own overflow, 160-cycle window
      wr(ADR_CTL, 8'h24);
      idle(2);
      #1;
      rx_n = 0;
      tx_n = 0;
      idle(160);
      #1;
      `CHK(rx_n, 10)
      `CHK(tx_n, 0)
      $display("test 6 done");
      // clock-out: pin enabled, no overflow flag
      wr(ADR_CTL, 8'h00);
      wr(ADR_MOD, 8'h02);
      wcnt(8'hFF, 8'hF0);
      wr(ADR_CTL, 8'h04);
      idle(12);
      `CHK(oe_n, 1'b0)
      co_n = 0;
      idle(400);
      `CHK(co_n >= 2, 1'b1)
      cr(ADR_CTL, 8'h04);
      $display("test 7 done");
      print_verdict();
   end
endmodule // timer2_capture_reload_counter_test
`default_nettype wire
